// ==== clrm_ctl_reg.v ====
// Purpose: One 8-bit rail control register with its effective state and selection
// Assumes: Write strobe and exit event come from logic on clk
// Notes:   Reserved codes are stored but never reach the effective outputs
`timescale 1ns/1ps
`default_nettype none
`include "clrm_regs.vh"

module clrm_ctl_reg #(
    parameter [7:0] ADDR    = 8'h00,
    parameter [0:0] HAS_SEL = 1'b1
) (
    // Clock and reset
    input  wire       clk,
    input  wire       resetn,
    // Register write port
    input  wire [7:0] reg_addr,
    input  wire       reg_wr,
    input  wire [7:0] reg_wdata,
    // Standby exit event, one cycle
    input  wire       exit_evt,
    // Register contents and decoded values
    output reg  [7:0] reg_q,
    output reg  [1:0] state_q,
    output reg  [1:0] sel_q
);

    reg [7:0] reg_d;
    reg [1:0] state_d;
    reg [1:0] sel_d;

    always @* begin
        reg_d   = reg_q;
        state_d = state_q;
        sel_d   = sel_q;
        if (reg_wr && (reg_addr == ADDR)) begin
            reg_d = reg_wdata;
            if (!HAS_SEL) begin
                reg_d[`CLRM_SEL_MSB:`CLRM_SEL_LSB] = 2'h0;
            end
        end
        // Exit codes 0..3 mean do not copy
        if (exit_evt && reg_d[`CLRM_EX_MSB]) begin
            reg_d[`CLRM_ST_MSB:`CLRM_ST_LSB] = reg_d[`CLRM_EX_MSB:`CLRM_EX_LSB];
        end
        // Reserved state codes keep the rail where it was
        if (reg_d[`CLRM_ST_LSB + `CLRM_CODE_VALID]) begin
            if (reg_d[`CLRM_ST_LSB + 1]) begin
                state_d = `CLRM_RAIL_ACT;
            end else if (reg_d[`CLRM_ST_LSB]) begin
                state_d = `CLRM_RAIL_LOW;
            end else begin
                state_d = `CLRM_RAIL_OFF;
            end
        end
        // Only codes 0 and 1 select a voltage
        if (HAS_SEL && !reg_d[`CLRM_SEL_MSB]) begin
            sel_d = reg_d[`CLRM_SEL_MSB:`CLRM_SEL_LSB];
        end
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_q   <= `CLRM_RST_VAL;
            state_q <= `CLRM_RAIL_OFF;
            sel_q   <= `CLRM_SEL_A;
        end else begin
            reg_q   <= reg_d;
            state_q <= state_d;
            sel_q   <= sel_d;
        end
    end

endmodule // clrm_ctl_reg

`default_nettype wire

// ==== clrm_host.sv ====
// Purpose: Host model that programs the rail registers
// Assumes: Strobes launched just after a rising clk edge
// Notes:   Released address and data lines show the inverse value
`timescale 1ns/1ps
`default_nettype none
module clrm_host (
    // Bus
    input  wire logic       clk,
    input  wire logic [7:0] rdata,
    input  wire logic       rvalid,
    output var  logic [7:0] addr,
    output var  logic [7:0] wdata,
    output var  logic       wr,
    output var  logic       rd
);
    initial begin
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
    end
    // Exit fields are written before any standby exit is relied on
    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask
    task automatic rd8(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        // Sampled mid-cycle, where read data and valid have settled
        @(negedge clk);
        d = rdata;
        v = rvalid;
        @(posedge clk);
    endtask
endmodule // clrm_host
`default_nettype wire

// ==== clrm_rail_mapper.v ====
// Purpose: Maps the io and wireless rail registers onto the two comm regulators
// Assumes: Chip register interface on clk; standby exit pin is asynchronous
// Notes:   Exit copy acts on the rising edge of the synchronised pin
//
// Contract
// - State field 2:0, exit field 5:3 decoded
// - Standby exit loads exit states into rails
// - Io register bits 7:6 select 1.8/2.5 V
// - Wireless register bits 7:6 select 1.2/1.3 V
// - Io at 1.8 V drives positioning regulator
// - Io at 2.5 V drives wlan regulator
// - Wireless at 1.2 V drives wlan regulator
// - Wireless at 1.3 V drives positioning regulator
// - Positioning at 1.3 V raises 1.5 V switcher
// - Io register at 0x4a, reset 0x24
// - Wireless register at 0x4b, reset 0x24
// - Positioning regulator discharged while off
// - Standalone 1.8 V regulator register at 0x4c
`timescale 1ns/1ps
`default_nettype none
`include "clrm_regs.vh"

module clrm_rail_mapper (
    // Clock and reset
    input  wire       clk,
    input  wire       resetn,
    // Chip register interface
    input  wire [7:0] reg_addr,
    input  wire       reg_wr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    output reg        reg_rvalid,
    // Standby exit pin
    input  wire       standby_exit_pin,
    // Positioning regulator
    output reg  [1:0] positioning_regulator_state,
    output reg        positioning_regulator_vsel_1v3,
    output reg        positioning_regulator_discharge,
    // Wlan regulator
    output reg  [1:0] wlan_regulator_state,
    output reg        wlan_regulator_vsel_2v5,
    output reg        wlan_regulator_discharge,
    // Standalone 1.8 V comm regulator
    output reg  [1:0] comm18_regulator_state,
    output reg        comm18_regulator_discharge,
    // Supply and status
    output reg        supply_1v5_switcher_boost,
    output reg        rail_conflict
);

    localparam integer IO_IDX  = 0;
    localparam integer WL_IDX  = 1;
    localparam integer C18_IDX = 2;

    // Pin synchroniser and edge detect
    reg        exit_meta_q;
    reg        exit_sync_q;
    reg        exit_prev_q;
    wire       exit_evt;

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            exit_meta_q <= 1'b0;
            exit_sync_q <= 1'b0;
            exit_prev_q <= 1'b0;
        end else begin
            exit_meta_q <= standby_exit_pin;
            exit_sync_q <= exit_meta_q;
            exit_prev_q <= exit_sync_q;
        end
    end

    // A pin held high copies once; later writes then stick
    assign exit_evt = exit_sync_q & ~exit_prev_q;

    // Control registers
    wire [8*`CLRM_NREG-1:0] reg_flat;
    wire [2*`CLRM_NREG-1:0] state_flat;
    wire [2*`CLRM_NREG-1:0] sel_flat;

    genvar gi;
    generate
        for (gi = 0; gi < `CLRM_NREG; gi = gi + 1) begin : g_reg
            clrm_ctl_reg #(
                .ADDR    ((gi == IO_IDX) ? `CLRM_IO_ADDR :
                          (gi == WL_IDX) ? `CLRM_WL_ADDR : `CLRM_C18_ADDR),
                .HAS_SEL ((gi == C18_IDX) ? 1'b0 : 1'b1)
            ) u_reg (
                .clk       (clk),
                .resetn    (resetn),
                .reg_addr  (reg_addr),
                .reg_wr    (reg_wr),
                .reg_wdata (reg_wdata),
                .exit_evt  (exit_evt),
                .reg_q     (reg_flat[8*gi +: 8]),
                .state_q   (state_flat[2*gi +: 2]),
                .sel_q     (sel_flat[2*gi +: 2])
            );
        end
    endgenerate

    wire [1:0] io_state  = state_flat[2*IO_IDX +: 2];
    wire [1:0] io_sel    = sel_flat[2*IO_IDX +: 2];
    wire [1:0] wl_state  = state_flat[2*WL_IDX +: 2];
    wire [1:0] wl_sel    = sel_flat[2*WL_IDX +: 2];
    wire [1:0] c18_state = state_flat[2*C18_IDX +: 2];

    // Routing of register state onto regulators
    reg [1:0] pos_state_d;
    reg       pos_1v3_d;
    reg [1:0] wlan_state_d;
    reg       wlan_2v5_d;
    reg       conflict_d;

    always @* begin
        pos_state_d  = `CLRM_RAIL_OFF;
        pos_1v3_d    = 1'b0;
        wlan_state_d = `CLRM_RAIL_OFF;
        wlan_2v5_d   = 1'b0;
        // Wireless first so the io register wins a conflict
        if (wl_sel == `CLRM_SEL_A) begin
            wlan_state_d = wl_state;
            wlan_2v5_d   = 1'b0;
        end else begin
            pos_state_d  = wl_state;
            pos_1v3_d    = 1'b1;
        end
        if (io_sel == `CLRM_SEL_A) begin
            pos_state_d  = io_state;
            pos_1v3_d    = 1'b0;
        end else begin
            wlan_state_d = io_state;
            wlan_2v5_d   = 1'b1;
        end
        // Firmware is trusted here; flag only, no protection
        conflict_d = (io_sel == wl_sel) ? 1'b0 : 1'b1;
    end

    // Output flops
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            positioning_regulator_state     <= `CLRM_RAIL_OFF;
            positioning_regulator_vsel_1v3  <= 1'b0;
            positioning_regulator_discharge <= 1'b1;
            wlan_regulator_state            <= `CLRM_RAIL_OFF;
            wlan_regulator_vsel_2v5         <= 1'b0;
            wlan_regulator_discharge        <= 1'b1;
            comm18_regulator_state          <= `CLRM_RAIL_OFF;
            comm18_regulator_discharge      <= 1'b1;
            supply_1v5_switcher_boost       <= 1'b0;
            rail_conflict                   <= 1'b0;
        end else begin
            positioning_regulator_state     <= pos_state_d;
            positioning_regulator_vsel_1v3  <= pos_1v3_d;
            positioning_regulator_discharge <= (pos_state_d == `CLRM_RAIL_OFF);
            wlan_regulator_state            <= wlan_state_d;
            wlan_regulator_vsel_2v5         <= wlan_2v5_d;
            wlan_regulator_discharge        <= (wlan_state_d == `CLRM_RAIL_OFF);
            comm18_regulator_state          <= c18_state;
            comm18_regulator_discharge      <= (c18_state == `CLRM_RAIL_OFF);
            supply_1v5_switcher_boost       <= pos_1v3_d;
            rail_conflict                   <= conflict_d;
        end
    end

    // Register read, one cycle latency
    reg [7:0] rdata_d;

    always @* begin
        case (reg_addr)
            `CLRM_IO_ADDR:  rdata_d = reg_flat[8*IO_IDX +: 8];
            `CLRM_WL_ADDR:  rdata_d = reg_flat[8*WL_IDX +: 8];
            `CLRM_C18_ADDR: rdata_d = reg_flat[8*C18_IDX +: 8];
            default:        rdata_d = `CLRM_UNMAPPED;
        endcase
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata  <= `CLRM_UNMAPPED;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= rdata_d;
            end
        end
    end

endmodule // clrm_rail_mapper

`default_nettype wire

// ==== clrm_rail_mapper_chk.sv ====
// Purpose: Port checks for the comm rail mapper
// Assumes: One clock, resetn async active low
// Notes:   Bound to clrm_rail_mapper
`timescale 1ns/1ps
`default_nettype none
module clrm_rail_mapper_chk (
    // Clock and bus
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_rvalid,
    input wire logic       standby_exit_pin,
    // Rails
    input wire logic [1:0] positioning_regulator_state,
    input wire logic       positioning_regulator_vsel_1v3,
    input wire logic       positioning_regulator_discharge,
    input wire logic [1:0] wlan_regulator_state,
    input wire logic       wlan_regulator_discharge,
    input wire logic       supply_1v5_switcher_boost
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    sequence s_wr_rd;
        (reg_wr && reg_addr == 8'h4a) ##1 !reg_wr ##1 (reg_rd && !reg_wr && reg_addr == 8'h4a);
    endsequence
    sequence s_io_wr;
        reg_wr && reg_addr == 8'h4a && reg_wdata[7:6] == 2'h0 && reg_wdata[2];
    endsequence
    AST_RVALID: assert property (reg_rvalid == $past(reg_rd))
        else $error("read valid not one cycle after read");
    AST_WRRD: assert property (s_wr_rd |=> reg_rdata == $past(reg_wdata, 3))
        else $error("read back differs from written byte");
    AST_UNMAP: assert property (reg_rd && (reg_addr < 8'h4a || reg_addr > 8'h4c)
        |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_IOWR: assert property (s_io_wr |=> ##1 positioning_regulator_state ==
        ($past(reg_wdata, 2) & 8'h02 ? 2'h2 : {1'b0, $past(reg_wdata[0], 2)}))
        else $error("io write did not reach positioning rail");
    AST_CODE: assert property (positioning_regulator_state != 2'h3 && wlan_regulator_state != 2'h3)
        else $error("illegal rail state");
    AST_PDIS: assert property ((positioning_regulator_state == 2'h0) == positioning_regulator_discharge)
        else $error("positioning discharge mismatch");
    AST_WDIS: assert property ((wlan_regulator_state == 2'h0) == wlan_regulator_discharge)
        else $error("wlan discharge mismatch");
    AST_BOOST: assert property (positioning_regulator_vsel_1v3 |-> supply_1v5_switcher_boost)
        else $error("switcher not raised at 1.3 V");
    AST_HOLD: assert property ((!reg_wr && !standby_exit_pin) [*6] |=>
        $stable(positioning_regulator_state) && $stable(wlan_regulator_state))
        else $error("rail state moved without cause");
endmodule // clrm_rail_mapper_chk
bind clrm_rail_mapper clrm_rail_mapper_chk chk_u (.clk, .resetn, .reg_addr, .reg_wr, .reg_wdata,
    .reg_rd, .reg_rdata, .reg_rvalid, .standby_exit_pin, .positioning_regulator_state,
    .positioning_regulator_vsel_1v3, .positioning_regulator_discharge, .wlan_regulator_state,
    .wlan_regulator_discharge, .supply_1v5_switcher_boost);
`default_nettype wire

// ==== clrm_rail_mapper_tb.sv ====
// Purpose: Self-checking bench for the comm rail mapper
// Assumes: Host model drives the register port
// Notes:   Rows hold io byte, wireless byte and expected rails
`timescale 1ns/1ps
`default_nettype none
module clrm_rail_mapper_tb;
    logic       clk, resetn, pin, wr, rd, rv, pv, wv, pd, wd, cd, bst, cf, vd;
    logic [7:0] addr, wdata, rdata, d;
    logic [1:0] ps, ws, cs;
    int         n_errors, total_checks, cyc;
    // Each row aims the two registers at different regulators
    logic [22:0] rows [4] = '{
        {8'h06, 8'h24, 7'h40},
        {8'h65, 8'h66, 7'h57},
        {8'h64, 8'h67, 7'h53},
        {8'h25, 8'h25, 7'h24}};
    clrm_host host_u (.clk(clk), .rdata(rdata), .rvalid(rv), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd));
    clrm_rail_mapper dut_u (.clk(clk), .resetn(resetn), .reg_addr(addr), .reg_wr(wr),
        .reg_wdata(wdata), .reg_rd(rd), .reg_rdata(rdata), .reg_rvalid(rv),
        .standby_exit_pin(pin), .positioning_regulator_state(ps),
        .positioning_regulator_vsel_1v3(pv), .positioning_regulator_discharge(pd),
        .wlan_regulator_state(ws), .wlan_regulator_vsel_2v5(wv),
        .wlan_regulator_discharge(wd), .comm18_regulator_state(cs),
        .comm18_regulator_discharge(cd), .supply_1v5_switcher_boost(bst), .rail_conflict(cf));
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        host_u.rd8(a, d, vd);
        chk("rvalid", {7'h00, vd}, 8'h01);
        chk("rdata", d, e);
    endtask
    task automatic stop_test;
        if (n_errors == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Guards against a hung handshake
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_errors++;
            stop_test();
        end
    end
    initial begin
        resetn = 1'b0;
        pin = 1'b0;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        chk("rst", {cf, ps, pv, ws, wv, bst}, 8'h00);
        chk("dis", {3'h0, cs, pd, wd, cd}, 8'h07);
        rdchk(8'h4a, 8'h24);
        rdchk(8'h4b, 8'h24);
        rdchk(8'h4c, 8'h24);
        rdchk(8'h50, 8'h00);
        foreach (rows[i]) begin
            host_u.wr8(8'h4a, rows[i][22:15]);
            host_u.wr8(8'h4b, rows[i][14:7]);
            repeat (2) @(posedge clk);
            chk("rails", {cf, ps, pv, ws, wv, bst}, {1'b0, rows[i][6:0]});
            rdchk(8'h4b, rows[i][14:7]);
        end
        // Reserved state and selection codes are stored but not applied
        host_u.wr8(8'h4a, 8'h23);
        rdchk(8'h4a, 8'h23);
        host_u.wr8(8'h4b, 8'ha5);
        repeat (2) @(posedge clk);
        chk("resv", {cf, ps, pv, ws, wv, bst}, 8'h24);
        host_u.wr8(8'h4a, 8'h30);
        pin <= 1'b1;
        repeat (6) @(posedge clk);
        chk("exit", {cf, ps, pv, ws, wv, bst}, 8'h40);
        rdchk(8'h4a, 8'h36);
        // Both registers on one regulator: flagged, the io register keeps it
        host_u.wr8(8'h4b, 8'h66);
        repeat (2) @(posedge clk);
        chk("conf", {cf, ps, pv, ws, wv, bst}, 8'hc0);
        // Reset in mid-run; the pin drops so the next exit re-arms
        resetn <= 1'b0;
        pin <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        chk("rst2", {cf, ps, pv, ws, wv, bst}, 8'h00);
        chk("dis2", {3'h0, cs, pd, wd, cd}, 8'h07);
        rdchk(8'h4a, 8'h24);
        rdchk(8'h4b, 8'h24);
        // Standalone register drops the selection bits
        host_u.wr8(8'h4c, 8'hc6);
        repeat (2) @(posedge clk);
        chk("c18", {3'h0, cs, pd, wd, cd}, 8'h16);
        rdchk(8'h4c, 8'h06);
        // Exit code 0 must not copy into the state field
        host_u.wr8(8'h4a, 8'h06);
        pin <= 1'b1;
        repeat (6) @(posedge clk);
        chk("nocopy", {cf, ps, pv, ws, wv, bst}, 8'h40);
        rdchk(8'h4a, 8'h06);
        stop_test();
    end
endmodule // clrm_rail_mapper_tb
`default_nettype wire

// ==== clrm_regs.vh ====
// Purpose: Offsets, field positions, reset values and codes of the comm rail mapper
// Assumes: Included by bare name from every clrm design file
// Notes:   Definitions only
`ifndef CLRM_REGS_VH
`define CLRM_REGS_VH

// Register byte addresses
`define CLRM_IO_ADDR      8'h4a
`define CLRM_WL_ADDR      8'h4b
`define CLRM_C18_ADDR     8'h4c
`define CLRM_NREG         3

// Reset value of every control register
`define CLRM_RST_VAL      8'h24

// Field positions
`define CLRM_ST_LSB       0
`define CLRM_ST_MSB       2
`define CLRM_EX_LSB       3
`define CLRM_EX_MSB       5
`define CLRM_SEL_LSB      6
`define CLRM_SEL_MSB      7

// Bit that marks a state code as meaningful (codes 4..7)
`define CLRM_CODE_VALID   2

// Rail state encoding on the outputs
`define CLRM_RAIL_OFF     2'h0
`define CLRM_RAIL_LOW     2'h1
`define CLRM_RAIL_ACT     2'h2

// Voltage selection codes
`define CLRM_SEL_A        2'h0
`define CLRM_SEL_B        2'h1

// Read data for an unmapped address
`define CLRM_UNMAPPED     8'h00

`endif
